// >>> inc/tcf_map.svh
`ifndef TCF_MAP_SVH
`define TCF_MAP_SVH
`define TCF_A_MODE 8'h00
`define TCF_A_OPSEL 8'h04
`define TCF_A_DLY1 8'h08
`define TCF_A_DLY2 8'h0c
`define TCF_A_DLY3 8'h10
`define TCF_A_PULSE 8'h14
`define TCF_A_ISTAT 8'h18
`define TCF_A_IMASK 8'h1c
`define TCF_A_RESULT 8'h20
`define TCF_RESP_OKAY 2'b00
`define TCF_RESP_SLVERR 2'b10
`define TCF_MODE_BIT 0
`define TCF_MIN_LSB 16
`define TCF_SUB_LSB 20
`define TCF_DLY_MSB 18
`define TCF_EDGE_A_BIT 19
`define TCF_EDGE_B_BIT 20
`define TCF_IEN_ALU_BIT 21
`define TCF_IEN_TMO_BIT 23
`define TCF_TMO_LSB 19
`define TCF_FERR_BIT 21
`define TCF_PHASE_MSB 15
`define TCF_REP_LSB 16
`define TCF_REP_MSB 18
`define TCF_JOFF_BIT 19
`define TCF_SJON_BIT 20
`define TCF_DIS_A_BIT 21
`define TCF_DIS_B_BIT 22
`define TCF_INV_B_BIT 23
`define TCF_PULSE_RST 24'h080000
`define TCF_IMASK_RST 3'h0
`define TCF_FRAC_BITS 5
`define TCF_REF_MHZ 4
`define TCF_TMO0_US 64
`define TCF_CODE_NOP 4'h5
`define TCF_CODE_UNDEF 4'h8
`define TCF_CODE_MAX 4'hc
`endif

// >>> inc/tcf_pkg.sv
package tcf_pkg;
  typedef logic [31:0] tcf_evt_t;
  typedef logic [12:0][31:0] tcf_evt_vec_t;
  typedef enum logic {TCF_SHORT = 1'b0, TCF_LONG = 1'b1} tcf_range_t;
  typedef enum logic [1:0] {
    TCF_TMO_64 = 2'b00,
    TCF_TMO_256 = 2'b01,
    TCF_TMO_1024 = 2'b10,
    TCF_TMO_4096 = 2'b11
  } tcf_tmo_sel_t;
endpackage

// >>> inc/tcf_cfg_if.sv
`timescale 1ns/10ps
`default_nettype none
interface tcf_cfg_if;
  import tcf_pkg::*;
  tcf_range_t range;
  logic [3:0] minuend_event_select;
  logic [3:0] subtrahend_event_select;
  logic force_error_result;
  logic [18:0] stop_window_delay_a;
  logic [18:0] stop_window_delay_b;
  logic [18:0] stop_window_delay_c;
  tcf_tmo_sel_t long_range_timeout_select;
  modport src (output range, minuend_event_select, subtrahend_event_select,
    force_error_result, stop_window_delay_a, stop_window_delay_b,
    stop_window_delay_c, long_range_timeout_select);
  modport alu (input range, minuend_event_select, subtrahend_event_select,
    force_error_result);
  modport win (input range, stop_window_delay_a, stop_window_delay_b,
    stop_window_delay_c, long_range_timeout_select);
endinterface
`default_nettype wire

// >>> rtl/tcf_alu.sv
`timescale 1ns/10ps
`default_nettype none
`include "tcf_map.svh"
module tcf_alu
  import tcf_pkg::*;
(
  input wire logic clk,
  input wire logic rst_n,
  input wire logic ce,
  input wire logic alu_go,
  input wire logic timeout,
  input wire tcf_evt_vec_t events,
  tcf_cfg_if.alu cfg,
  output tcf_evt_t result,
  output logic done
);
  typedef struct packed {
    tcf_evt_t res;
    logic done;
  } tcf_alu_t;
  tcf_alu_t s;
  tcf_alu_t next_s;
  logic [4:0] m;
  logic [4:0] d;

  // Returns {valid, event index}; index follows the code in short range.
  function automatic logic [4:0] pick(logic [3:0] c, tcf_range_t r,
                                      logic sub);
    if (r == TCF_LONG) begin
      if (!sub)
        return {c == 4'h1, 4'h0};
      return {c >= 4'h2 && c <= 4'h4, c - 4'h1};
    end
    return {c <= `TCF_CODE_MAX && c != `TCF_CODE_NOP &&
            c != `TCF_CODE_UNDEF, c};
  endfunction

  always_comb begin
    m = pick(cfg.minuend_event_select, cfg.range, 1'b0);
    d = pick(cfg.subtrahend_event_select, cfg.range, 1'b1);
    next_s = s;
    next_s.done = 1'b0;
    if (timeout && cfg.force_error_result) begin
      next_s.res = 32'hffffffff;
      next_s.done = 1'b1;
    end else if (alu_go && m[4] && d[4]) begin
      next_s.done = 1'b1;
      if (cfg.range == TCF_LONG)
        next_s.res = events[d[3:0]] - events[m[3:0]];
      else
        next_s.res = events[m[3:0]] - events[d[3:0]];
    end
  end

  always_ff @(posedge clk) begin
    if (!rst_n)
      s <= '0;
    else if (ce)
      s <= next_s;
  end

  assign result = s.res;
  assign done = s.done;

  ////////////////////////////////////////////////////////////////////////////
  tcf_evt_t chk_short;
  tcf_evt_t chk_long;
  assign chk_short = events[9] - events[3];
  assign chk_long = events[3] - events[0];
  default clocking @(posedge clk); endclocking
  default disable iff (!rst_n);
  alu_short_sel_a: assert property (
    ce && alu_go && !timeout && cfg.range == TCF_SHORT &&
    cfg.minuend_event_select == 4'h9 && cfg.subtrahend_event_select == 4'h3
    |=> done && result == $past(chk_short))
    else $error("short range difference wrong");
  alu_long_sel_a: assert property (
    ce && alu_go && !timeout && cfg.range == TCF_LONG &&
    cfg.minuend_event_select == 4'h1 && cfg.subtrahend_event_select == 4'h4
    |=> done && result == $past(chk_long))
    else $error("long range difference wrong");
  alu_nop_code_a: assert property (
    ce && !timeout && cfg.range == TCF_SHORT &&
    (cfg.minuend_event_select == 4'h5 || cfg.minuend_event_select == 4'h8 ||
     cfg.minuend_event_select > 4'hc) |=> !done)
    else $error("undefined operand code acted");
  alu_err_force_a: assert property (
    ce && timeout && cfg.force_error_result |=> done && result == '1)
    else $error("timeout did not force all ones");
  alu_err_off_a: assert property (
    ce && timeout && !cfg.force_error_result && !alu_go |=> !done &&
    $stable(result))
    else $error("timeout forced result while disabled");
  alu_long_done_c: cover property (done && cfg.range == TCF_LONG);
endmodule
`default_nettype wire

// >>> rtl/tcf_window.sv
`timescale 1ns/10ps
`default_nettype none
`include "tcf_map.svh"
module tcf_window
  import tcf_pkg::*;
#(
  parameter logic [14:0] TMO_BASE = 15'd256
) (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic ce,
  input wire logic ref_tick,
  input wire logic meas_start,
  tcf_cfg_if.win cfg,
  output logic [2:0] stop_enable,
  output logic timeout
);
  typedef enum logic {TCF_IDLE = 1'b0, TCF_RUN = 1'b1} tcf_win_st_t;
  typedef struct packed {
    tcf_win_st_t st;
    logic [14:0] ticks;
    logic [2:0] en;
    logic tmo;
  } tcf_win_t;
  tcf_win_t s;
  tcf_win_t next_s;
  logic [14:0] limit;

  // Ticks count whole reference periods; the delay carries five fraction
  // bits, so the window opens at the first whole period at or past it.
  function automatic logic open_at(logic [14:0] t, logic [18:0] dl);
    return {t, {`TCF_FRAC_BITS{1'b0}}} >= {1'b0, dl};
  endfunction

  always_comb begin
    limit = TMO_BASE << {cfg.long_range_timeout_select, 1'b0};
    next_s = s;
    next_s.tmo = 1'b0;
    unique case (s.st)
      TCF_IDLE: begin
        if (meas_start) begin
          next_s.st = TCF_RUN;
          next_s.ticks = 15'h0000;
        end
      end
      TCF_RUN: begin
        if (meas_start)
          next_s.ticks = 15'h0000;
        else if (cfg.range == TCF_LONG && s.ticks >= limit) begin
          next_s.st = TCF_IDLE;
          next_s.tmo = 1'b1;
        end else if (ref_tick && s.ticks != 15'h7fff)
          next_s.ticks = s.ticks + 15'h0001;
      end
    endcase
    next_s.en[0] = next_s.st == TCF_RUN &&
      open_at(next_s.ticks, cfg.stop_window_delay_a);
    next_s.en[1] = next_s.st == TCF_RUN &&
      open_at(next_s.ticks, cfg.stop_window_delay_b);
    next_s.en[2] = next_s.st == TCF_RUN &&
      open_at(next_s.ticks, cfg.stop_window_delay_c);
  end

  always_ff @(posedge clk) begin
    if (!rst_n)
      s <= '0;
    else if (ce)
      s <= next_s;
  end

  assign stop_enable = s.en;
  assign timeout = s.tmo;

  ////////////////////////////////////////////////////////////////////////////
  logic [19:0] over_b;
  assign over_b = {s.ticks, 5'h00} - {1'b0, cfg.stop_window_delay_b};
  default clocking @(posedge clk); endclocking
  default disable iff (!rst_n);
  win_delay_a: assert property (
    stop_enable[0] |-> s.st == TCF_RUN &&
    {s.ticks, 5'h00} >= {1'b0, cfg.stop_window_delay_a})
    else $error("window a open before its delay");
  win_frac_b_a: assert property (
    $rose(stop_enable[1]) && $stable(cfg.stop_window_delay_b) |->
    over_b < 20'd32)
    else $error("window b opened late");
  win_tmo_len_a: assert property (
    timeout |-> $past(s.ticks) == $past(limit))
    else $error("timeout at wrong tick count");
  win_tmo_c: cover property (timeout);
endmodule
`default_nettype wire

// >>> rtl/tcf_config.sv
// Added by the designer: the register offsets and the AXI4-Lite slave port.
`timescale 1ns/10ps
`default_nettype none
`include "tcf_map.svh"

module tcf_config
  import tcf_pkg::*;
#(
  parameter logic [14:0] TMO_BASE_TICKS = 15'(`TCF_TMO0_US * `TCF_REF_MHZ)
) (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic ce,
  input wire logic [7:0] awaddr,
  input wire logic awvalid,
  output logic awready,
  input wire logic [31:0] wdata,
  input wire logic [3:0] wstrb,
  input wire logic wvalid,
  output logic wready,
  output logic [1:0] bresp,
  output logic bvalid,
  input wire logic bready,
  input wire logic [7:0] araddr,
  input wire logic arvalid,
  output logic arready,
  output logic [31:0] rdata,
  output logic [1:0] rresp,
  output logic rvalid,
  input wire logic rready,
  input wire logic ref_tick,
  input wire logic meas_start,
  input wire logic alu_go,
  input wire logic all_hits_in,
  input wire tcf_evt_vec_t events,
  input wire logic stop_pin_a,
  input wire logic stop_pin_b,
  output logic long_range_mode,
  output logic [2:0] stop_enable,
  output logic stop_hit_a,
  output logic stop_hit_b,
  output tcf_evt_t alu_result,
  output logic [15:0] pulse_phase_mask,
  output logic [2:0] pulse_repeat,
  output logic jitter_unit_off,
  output logic start_jitter_on,
  output logic pulse_out_a_off,
  output logic pulse_out_b_off,
  output logic pulse_out_b_invert,
  output logic irq
);
  typedef struct packed {
    logic aw_rdy;
    logic ar_rdy;
    logic bvalid;
    logic [1:0] bresp;
    logic rvalid;
    logic [1:0] rresp;
    logic [31:0] rdata;
    tcf_range_t range;
    logic [7:0] opsel;
    logic [23:0] dly1;
    logic [23:0] dly2;
    logic [23:0] dly3;
    logic [23:0] pulse;
    logic [2:0] istat;
    logic [2:0] imask;
    logic irq;
    logic [2:0] sync_a;
    logic [2:0] sync_b;
    logic lvl_a;
    logic lvl_b;
    logic edge_a;
    logic edge_b;
    logic [1:0] hits_a;
  } tcf_top_t;
  tcf_top_t s;
  tcf_top_t next_s;

  logic aw_hit;
  logic ar_hit;
  logic chg_a;
  logic chg_b;
  logic [2:0] rd_clr;
  logic [2:0] ev_set;
  logic [3:0] open_a;
  logic [2:0] win_en;
  logic win_tmo;
  logic alu_done;
  tcf_evt_t alu_res;
  logic [23:0] wr_opsel;

  ////////////////////////////////////////////////////////////////////////////
  tcf_cfg_if cfg ();

  assign cfg.range = s.range;
  assign cfg.minuend_event_select = s.opsel[3:0];
  assign cfg.subtrahend_event_select = s.opsel[7:4];
  assign cfg.force_error_result = s.dly2[`TCF_FERR_BIT];
  assign cfg.stop_window_delay_a = s.dly1[`TCF_DLY_MSB:0];
  assign cfg.stop_window_delay_b = s.dly2[`TCF_DLY_MSB:0];
  assign cfg.stop_window_delay_c = s.dly3[`TCF_DLY_MSB:0];
  assign cfg.long_range_timeout_select =
    tcf_tmo_sel_t'(s.dly2[`TCF_TMO_LSB +: 2]);

  tcf_window #(
    .TMO_BASE(TMO_BASE_TICKS)
  ) u_window (
    .clk(clk),
    .rst_n(rst_n),
    .ce(ce),
    .ref_tick(ref_tick),
    .meas_start(meas_start),
    .cfg(cfg.win),
    .stop_enable(win_en),
    .timeout(win_tmo)
  );

  tcf_alu u_alu (
    .clk(clk),
    .rst_n(rst_n),
    .ce(ce),
    .alu_go(alu_go),
    .timeout(win_tmo),
    .events(events),
    .cfg(cfg.alu),
    .result(alu_res),
    .done(alu_done)
  );

  ////////////////////////////////////////////////////////////////////////////
  // Byte lanes above the 24 implemented bits are simply dropped.
  function automatic logic [23:0] wr24(logic [23:0] old, logic [31:0] d,
                                       logic [3:0] st);
    logic [23:0] r;
    r = old;
    for (int i = 0; i < 3; i++) begin
      if (st[i])
        r[i*8 +: 8] = d[i*8 +: 8];
    end
    return r;
  endfunction

  always_comb begin
    aw_hit = s.aw_rdy && awvalid && wvalid;
    ar_hit = s.ar_rdy && arvalid;
    rd_clr = (ar_hit && araddr == `TCF_A_ISTAT) ? 3'h7 : 3'h0;
    ev_set = {win_tmo, all_hits_in, alu_done} &
      s.dly1[`TCF_IEN_TMO_BIT:`TCF_IEN_ALU_BIT];
    wr_opsel = wr24({s.opsel, 16'h0000}, wdata, wstrb);
    chg_a = s.sync_a[1] == s.sync_a[2] && s.sync_a[2] != s.lvl_a;
    chg_b = s.sync_b[1] == s.sync_b[2] && s.sync_b[2] != s.lvl_b;
    open_a = {1'b1, win_en};
    next_s = s;
    // Address and data are taken together, so one write needs both.
    next_s.aw_rdy = !s.aw_rdy && !s.bvalid && awvalid && wvalid;
    next_s.ar_rdy = !s.ar_rdy && !s.rvalid && arvalid;
    if (bready)
      next_s.bvalid = 1'b0;
    if (rready)
      next_s.rvalid = 1'b0;
    if (aw_hit) begin
      next_s.bvalid = 1'b1;
      next_s.bresp = `TCF_RESP_OKAY;
      case (awaddr)
        `TCF_A_MODE: begin
          if (wstrb[0])
            next_s.range = tcf_range_t'(wdata[`TCF_MODE_BIT]);
        end
        `TCF_A_OPSEL: next_s.opsel = wr_opsel[23:16];
        `TCF_A_DLY1: next_s.dly1 = wr24(s.dly1, wdata, wstrb);
        `TCF_A_DLY2: next_s.dly2 = wr24(s.dly2, wdata, wstrb);
        `TCF_A_DLY3: next_s.dly3 = wr24(s.dly3, wdata, wstrb);
        `TCF_A_PULSE: next_s.pulse = wr24(s.pulse, wdata, wstrb);
        `TCF_A_IMASK: begin
          if (wstrb[0])
            next_s.imask = wdata[2:0];
        end
        `TCF_A_ISTAT, `TCF_A_RESULT: begin
        end
        default: next_s.bresp = `TCF_RESP_SLVERR;
      endcase
    end
    if (ar_hit) begin
      next_s.rvalid = 1'b1;
      next_s.rresp = `TCF_RESP_OKAY;
      next_s.rdata = 32'h00000000;
      // The operand, delay and pulse words are write-only and read back as zero.
      case (araddr)
        `TCF_A_MODE: next_s.rdata = {31'h00000000, s.range};
        `TCF_A_ISTAT: next_s.rdata = {29'h00000000, s.istat};
        `TCF_A_IMASK: next_s.rdata = {29'h00000000, s.imask};
        `TCF_A_RESULT: next_s.rdata = alu_res;
        `TCF_A_OPSEL, `TCF_A_DLY1, `TCF_A_DLY2, `TCF_A_DLY3,
        `TCF_A_PULSE: begin
        end
        default: next_s.rresp = `TCF_RESP_SLVERR;
      endcase
    end
    // An event in the clearing read's cycle survives for the next read.
    next_s.istat = (s.istat & ~rd_clr) | ev_set;
    next_s.irq = |(next_s.istat & next_s.imask);
    next_s.sync_a = {s.sync_a[1:0], stop_pin_a};
    next_s.sync_b = {s.sync_b[1:0], stop_pin_b};
    if (chg_a)
      next_s.lvl_a = s.sync_a[2];
    if (chg_b)
      next_s.lvl_b = s.sync_b[2];
    next_s.edge_a = chg_a && (s.sync_a[2] || s.dly1[`TCF_EDGE_A_BIT]) &&
      open_a[s.hits_a];
    next_s.edge_b = chg_b &&
      (s.sync_b[2] || s.dly1[`TCF_EDGE_B_BIT]);
    if (meas_start)
      next_s.hits_a = 2'd0;
    else if (next_s.edge_a && s.hits_a != 2'd3)
      next_s.hits_a = s.hits_a + 2'd1;
  end

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      s <= '0;
      s.pulse <= `TCF_PULSE_RST;
      s.imask <= `TCF_IMASK_RST;
    end else if (ce) begin
      s <= next_s;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  assign awready = s.aw_rdy;
  assign wready = s.aw_rdy;
  assign bvalid = s.bvalid;
  assign bresp = s.bresp;
  assign arready = s.ar_rdy;
  assign rvalid = s.rvalid;
  assign rdata = s.rdata;
  assign rresp = s.rresp;
  assign long_range_mode = s.range;
  assign stop_enable = win_en;
  assign stop_hit_a = s.edge_a;
  assign stop_hit_b = s.edge_b;
  assign alu_result = alu_res;
  assign pulse_phase_mask = s.pulse[`TCF_PHASE_MSB:0];
  assign pulse_repeat = s.pulse[`TCF_REP_MSB:`TCF_REP_LSB];
  assign jitter_unit_off = s.pulse[`TCF_JOFF_BIT];
  assign start_jitter_on = s.pulse[`TCF_SJON_BIT];
  assign pulse_out_a_off = s.pulse[`TCF_DIS_A_BIT];
  assign pulse_out_b_off = s.pulse[`TCF_DIS_B_BIT];
  assign pulse_out_b_invert = s.pulse[`TCF_INV_B_BIT];
  assign irq = s.irq;

  ////////////////////////////////////////////////////////////////////////////
  logic [31:0] past_wdata;
  always_ff @(posedge clk) begin
    past_wdata <= wdata;
  end

  default clocking @(posedge clk); endclocking
  default disable iff (!rst_n);

  top_edge_single_a: assert property (
    ce && !s.dly1[`TCF_EDGE_A_BIT] && chg_a && !s.sync_a[2] |=> !stop_hit_a)
    else $error("channel a took a falling edge in single mode");
  top_edge_both_a: assert property (
    ce && s.dly1[`TCF_EDGE_A_BIT] && chg_a && !s.sync_a[2] &&
    open_a[s.hits_a] |=> stop_hit_a)
    else $error("channel a missed a falling edge in both mode");
  top_edge_b_a: assert property (
    ce && chg_b && !s.sync_b[2] |=> stop_hit_b == $past(s.dly1[20]))
    else $error("channel b edge sensitivity wrong");
  top_irq_tmo_a: assert property (
    ce && win_tmo && s.dly1[`TCF_IEN_TMO_BIT] && s.imask[2] |=> irq [*2])
    else $error("enabled timeout gave no interrupt");
  top_ien_gate_a: assert property (
    ce && !s.dly1[`TCF_IEN_ALU_BIT] && !s.istat[0] |=> !s.istat[0])
    else $error("disabled alu source set status");
  top_mode_wr_a: assert property (
    ce && aw_hit && awaddr == `TCF_A_MODE && wstrb[0] |=>
    long_range_mode == past_wdata[0])
    else $error("mode write not applied");
  top_fire_seq_a: assert property (
    ce && aw_hit && awaddr == `TCF_A_PULSE && wstrb == 4'hf |=>
    pulse_phase_mask == past_wdata[15:0] &&
    pulse_repeat == past_wdata[18:16])
    else $error("pulse sequence fields not applied");
  top_fire_out_a: assert property (
    ce && aw_hit && awaddr == `TCF_A_PULSE && wstrb[2] |=>
    pulse_out_b_invert == past_wdata[23] &&
    pulse_out_a_off == past_wdata[21] &&
    start_jitter_on == past_wdata[20])
    else $error("pulse output fields not applied");
  top_bresp_a: assert property (
    ce && aw_hit |=> bvalid)
    else $error("write answer missing");

  top_write_c: cover property (aw_hit);
  top_read_istat_c: cover property (ar_hit && araddr == `TCF_A_ISTAT);
  top_irq_c: cover property ($rose(irq));
endmodule
`default_nettype wire

// >>> bench/tcf_host.sv
`timescale 1ns/10ps
`default_nettype none
`include "tcf_map.svh"
module tcf_host (
  input wire logic clk,
  output logic [7:0] awaddr,
  output logic awvalid,
  input wire logic awready,
  output logic [31:0] wdata,
  output logic [3:0] wstrb,
  output logic wvalid,
  input wire logic wready,
  input wire logic [1:0] bresp,
  input wire logic bvalid,
  output logic bready,
  output logic [7:0] araddr,
  output logic arvalid,
  input wire logic arready,
  input wire logic [31:0] rdata,
  input wire logic [1:0] rresp,
  input wire logic rvalid,
  output logic rready,
  output logic hang
);
  initial begin
    {awaddr, awvalid, wdata, wstrb, wvalid, bready} = '0;
    {araddr, arvalid, rready, hang} = '0;
  end
  //////////////////////////////////////////////////////////////////////////
  // Released payload is inverted, so a stale value can never pass as valid.
  task automatic wr(input logic [7:0] a, input logic [31:0] d,
    output logic [1:0] r);
    int n;
    n = 0;
    @(posedge clk);
    awaddr <= a;
    wdata <= (a == `TCF_A_PULSE) ? (d | 32'h80000) : d;
    wstrb <= 4'hf;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    do begin
      @(posedge clk);
      n++;
    end while (!(awready && wready) && n < 64);
    awvalid <= 1'b0;
    wvalid <= 1'b0;
    awaddr <= ~a;
    wdata <= ~d;
    while (!bvalid && n < 64) begin
      @(posedge clk);
      n++;
    end
    r = bresp;
    bready <= 1'b0;
    if (n >= 64) begin
      hang <= 1'b1;
    end
  endtask
  //////////////////////////////////////////////////////////////////////////
  task automatic rd(input logic [7:0] a, output logic [31:0] d,
    output logic [1:0] r);
    int n;
    n = 0;
    @(posedge clk);
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    do begin
      @(posedge clk);
      n++;
    end while (!arready && n < 64);
    arvalid <= 1'b0;
    araddr <= ~a;
    while (!rvalid && n < 64) begin
      @(posedge clk);
      n++;
    end
    d = rdata;
    r = rresp;
    rready <= 1'b0;
    if (n >= 64) begin
      hang <= 1'b1;
    end
  endtask
endmodule
`default_nettype wire

// >>> bench/testbench.sv
`timescale 1ns/10ps
`default_nettype none
`include "tcf_map.svh"
module testbench;
  import tcf_pkg::*;
  logic clk = 1'b0;
  logic rst_n = 1'b0;
  logic ce = 1'b1;
  logic all_hits_in = 1'b0;
  logic [2:0] st = 3'h0;
  logic stop_pin_a = 1'b0;
  logic stop_pin_b = 1'b0;
  logic [7:0] awaddr, araddr;
  logic [31:0] wdata, rdata, alu_result, rd_data, exp_r;
  logic [3:0] wstrb, m, s;
  logic [1:0] bresp, rresp, resp;
  logic awvalid, awready, wvalid, wready, bvalid, bready, arvalid, arready;
  logic rvalid, rready, long_range_mode, stop_hit_a, stop_hit_b, irq, hang;
  logic jitter_unit_off, start_jitter_on, pulse_out_a_off, pulse_out_b_off;
  logic pulse_out_b_invert;
  logic [2:0] stop_enable, pulse_repeat;
  logic [15:0] pulse_phase_mask;
  logic [23:0] pcfg;
  tcf_evt_vec_t events;
  int checks = 0;
  int mismatches = 0;
  int hits_a = 0;
  int hits_b = 0;
  assign pcfg = {pulse_out_b_invert, pulse_out_b_off, pulse_out_a_off,
    start_jitter_on, jitter_unit_off, pulse_repeat, pulse_phase_mask};
  always #4 clk = ~clk;
  tcf_config #(.TMO_BASE_TICKS(15'h4)) tcf_config_inst (
    .clk(clk), .rst_n(rst_n), .ce(ce), .awaddr(awaddr), .awvalid(awvalid),
    .awready(awready), .wdata(wdata), .wstrb(wstrb), .wvalid(wvalid),
    .wready(wready), .bresp(bresp), .bvalid(bvalid), .bready(bready),
    .araddr(araddr), .arvalid(arvalid), .arready(arready), .rdata(rdata),
    .rresp(rresp), .rvalid(rvalid), .rready(rready), .ref_tick(st[0]),
    .meas_start(st[1]), .alu_go(st[2]), .all_hits_in(all_hits_in),
    .events(events), .stop_pin_a(stop_pin_a), .stop_pin_b(stop_pin_b),
    .long_range_mode(long_range_mode), .stop_enable(stop_enable),
    .stop_hit_a(stop_hit_a), .stop_hit_b(stop_hit_b),
    .alu_result(alu_result), .pulse_phase_mask(pulse_phase_mask),
    .pulse_repeat(pulse_repeat), .jitter_unit_off(jitter_unit_off),
    .start_jitter_on(start_jitter_on), .pulse_out_a_off(pulse_out_a_off),
    .pulse_out_b_off(pulse_out_b_off),
    .pulse_out_b_invert(pulse_out_b_invert), .irq(irq));
  tcf_host tcf_host_inst (
    .clk(clk), .awaddr(awaddr), .awvalid(awvalid), .awready(awready),
    .wdata(wdata), .wstrb(wstrb), .wvalid(wvalid), .wready(wready),
    .bresp(bresp), .bvalid(bvalid), .bready(bready), .araddr(araddr),
    .arvalid(arvalid), .arready(arready), .rdata(rdata), .rresp(rresp),
    .rvalid(rvalid), .rready(rready), .hang(hang));
  //////////////////////////////////////////////////////////////////////////
  function automatic logic [31:0] ev(input int i);
    return 32'(i * i * 37 + 5);
  endfunction
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    checks++;
    if (seen !== exp) begin
      mismatches++;
      $display("mismatch at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic summarize;
    $display("checks %0d mismatches %0d", checks, mismatches);
    if (mismatches == 0 && checks > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask
  // Outputs are read one step after the edge, once its updates have landed.
  task automatic cyc(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask
  task automatic strobe(input logic [2:0] p);
    @(posedge clk);
    st <= p;
    @(posedge clk);
    st <= 3'h0;
    cyc(2);
  endtask
  task automatic tick(input int n);
    repeat (n) strobe(3'h1);
  endtask
  task automatic w(input logic [7:0] a, input logic [31:0] d);
    tcf_host_inst.wr(a, d, resp);
    cyc(1);
  endtask
  task automatic r(input logic [7:0] a, input logic [31:0] d,
    input logic [1:0] e);
    tcf_host_inst.rd(a, rd_data, resp);
    check(rd_data, d);
    check(resp, e);
    cyc(1);
  endtask
  task automatic pins(input logic v);
    @(posedge clk);
    stop_pin_a <= v;
    stop_pin_b <= v;
    cyc(8);
  endtask
  always @(posedge clk) begin
    if (stop_hit_a === 1'b1) begin
      hits_a++;
    end
    if (stop_hit_b === 1'b1) begin
      hits_b++;
    end
  end
  always @(posedge hang) begin
    mismatches++;
    summarize();
  end
  //////////////////////////////////////////////////////////////////////////
  initial begin
    for (int i = 0; i < 13; i++) events[i] = ev(i);
    repeat (12) @(posedge clk);
    rst_n <= 1'b1;
    cyc(1);
    check(pcfg, `TCF_PULSE_RST);
    check({long_range_mode, irq, stop_enable}, 32'h0);
    for (int i = 0; i < 2; i++) begin
      w(`TCF_A_PULSE, {8'h0, 48'he9a5a5_170001 >> (24 * i)});
      check(pcfg, (48'he9a5a5_170001 >> (24 * i)) & 24'hffffff | 24'h80000);
    end
    r(`TCF_A_PULSE, 32'h0, `TCF_RESP_OKAY);
    r(8'h24, 32'h0, `TCF_RESP_SLVERR);
    w(8'h24, 32'h1);
    check(resp, `TCF_RESP_SLVERR);
    for (int i = 0; i < 11; i++) begin
      m = 4'(44'hcba97643210 >> (4 * i));
      s = 4'(44'hcba97643210 >> (40 - 4 * i));
      w(`TCF_A_OPSEL, {8'h0, s, m, 16'h0});
      strobe(3'h4);
      exp_r = ev(int'(m)) - ev(int'(s));
      check(alu_result, exp_r);
    end
    // Codes without a defined event must leave the last result in place.
    for (int i = 0; i < 4; i++) begin
      m = 4'(16'hfd85 >> (4 * i));
      w(`TCF_A_OPSEL, {8'h0, i[0] ? m : 4'h0, i[0] ? 4'h0 : m, 16'h0});
      strobe(3'h4);
      check(alu_result, exp_r);
    end
    w(`TCF_A_DLY1, 32'h200040);
    w(`TCF_A_IMASK, 32'h1);
    w(`TCF_A_OPSEL, 32'h210000);
    strobe(3'h4);
    exp_r = ev(1) - ev(2);
    check(irq, 1'b1);
    r(`TCF_A_ISTAT, 32'h1, `TCF_RESP_OKAY);
    check(irq, 1'b0);
    w(`TCF_A_IMASK, 32'h0);
    strobe(3'h4);
    check(irq, 1'b0);
    r(`TCF_A_ISTAT, 32'h1, `TCF_RESP_OKAY);
    r(`TCF_A_RESULT, exp_r, `TCF_RESP_OKAY);
    w(`TCF_A_DLY1, 32'h400040);
    @(posedge clk);
    all_hits_in <= 1'b1;
    @(posedge clk);
    all_hits_in <= 1'b0;
    r(`TCF_A_ISTAT, 32'h2, `TCF_RESP_OKAY);
    w(`TCF_A_DLY2, 32'h41);
    w(`TCF_A_DLY3, 32'h60);
    strobe(3'h2);
    for (int t = 0; t < 4; t++) begin
      check(stop_enable, {t * 32 >= 96, t * 32 >= 65, t * 32 >= 64});
      strobe(3'h1);
    end
    for (int e = 0; e < 2; e++) begin
      w(`TCF_A_DLY1, 32'h200040 | (e * 32'h180000));
      hits_a = 0;
      hits_b = 0;
      pins(1'b1);
      pins(1'b0);
      check(hits_a, e + 1);
      check(hits_b, e + 1);
    end
    w(`TCF_A_MODE, 32'h1);
    check(long_range_mode, 1'b1);
    w(`TCF_A_OPSEL, 32'h410000);
    exp_r = ev(3) - ev(0);
    // The fifth pass keeps the shortest timeout but turns forcing off.
    for (int k = 0; k < 5; k++) begin
      w(`TCF_A_DLY2, (k < 4) ? (32'h200000 | (k << 19)) : 32'h0);
      strobe(3'h4);
      check(alu_result, exp_r);
      strobe(3'h2);
      tick((4 << (2 * (k % 4))) - 1);
      check(alu_result, exp_r);
      tick(1);
      cyc(2);
      check(alu_result, (k < 4) ? 32'hffffffff : exp_r);
    end
    summarize();
  end
endmodule
`default_nettype wire
